// ### hdl/gfs_map.svh
// register map, field positions, reset values and timing counts
`ifndef GFS_MAP_SVH
`define GFS_MAP_SVH

// ***********************************************************************
// register byte offsets
// ***********************************************************************
`define GFS_OFF_CTRL     6'h00
`define GFS_OFF_VPHASE   6'h04
`define GFS_OFF_HPHASE   6'h08
`define GFS_OFF_SCPHASE  6'h0C
`define GFS_OFF_PPM      6'h10
`define GFS_OFF_PROC     6'h14
`define GFS_OFF_PROC2    6'h18
`define GFS_OFF_STATUS   6'h1C
`define GFS_OFF_HOURS    6'h20
`define GFS_OFF_ID       6'h24

// ***********************************************************************
// field positions
// ***********************************************************************
`define GFS_CTRL_SRC_LSB     0
`define GFS_CTRL_PROC_EN     2
`define GFS_CTRL_HUE_MODE    3
`define GFS_CTRL_DEFAULTS    4
`define GFS_CTRL_HEALTH_LSB  8

// ***********************************************************************
// reset values and trim limits
// ***********************************************************************
`define GFS_UNITY_GAIN    8'h80
`define GFS_UNITY_OFFSET  8'h00
`define GFS_UNITY_HUE     8'h00
`define GFS_PPM_MAX       5'sd8
`define GFS_PPM_MIN       -5'sd8

// ***********************************************************************
// timing: hours tick every 3.75 minutes = 225 s
// ***********************************************************************
`define GFS_HOUR_TICK_S    225
`define GFS_CLK_HZ         20000000
`define GFS_HOUR_TICK_CYC  (64'(`GFS_HOUR_TICK_S) * 64'(`GFS_CLK_HZ))
`define GFS_HOUR_TICKS_PER_HOUR 16
`define GFS_SIG_TIMEOUT_CYC 64'd2000000

`endif

// ### hdl/gfs_pkg.sv
// types shared by the genlock frame sync block
package gfs_pkg;

   typedef enum logic [1:0] {
      GFS_SRC_REF  = 2'h0,
      GFS_SRC_SDI  = 2'h1,
      GFS_SRC_FREE = 2'h2
   } gfs_src_t;

   typedef enum logic [2:0] {
      GFS_REF_NONE  = 3'h0,
      GFS_REF_CSYNC = 3'h1,
      GFS_REF_BBURST= 3'h2,
      GFS_REF_TRI   = 3'h3,
      GFS_REF_VDRV  = 3'h4,
      GFS_REF_SQW   = 3'h5
   } gfs_ref_kind_t;

   typedef enum logic [1:0] {
      GFS_LOCK_LOCKED = 2'h0,
      GFS_LOCK_UNLOCK = 2'h1,
      GFS_LOCK_FREE   = 2'h2
   } gfs_lock_t;

   typedef enum logic [1:0] {
      GFS_HLTH_OK    = 2'h0,
      GFS_HLTH_BUSY  = 2'h1,
      GFS_HLTH_FAIL  = 2'h2
   } gfs_health_t;

   typedef enum logic [1:0] {
      GFS_SDI_SD  = 2'h0,
      GFS_SDI_HD  = 2'h1,
      GFS_SDI_3G  = 2'h2,
      GFS_SDI_BAD = 2'h3
   } gfs_sdi_rate_t;

   // one video sample: luma and two colour-difference components
   typedef struct packed {
      logic              valid;
      logic [9:0]        y;
      logic signed [9:0] cb;
      logic signed [9:0] cr;
   } gfs_pix_t;

   // reference front end observations
   typedef struct packed {
      logic          ref_frame;
      gfs_ref_kind_t ref_kind;
      logic          sdi_frame;
      gfs_sdi_rate_t sdi_rate;
   } gfs_ref_obs_t;

   // output timing strobes
   typedef struct packed {
      logic frame_start;
      logic line_start;
      logic sc_zero;
   } gfs_tim_t;

endpackage

// ### hdl/gfs_proc_amp.sv
// processing amplifier: offset, gain, saturation and hue rotation
module gfs_proc_amp (
   input  wire logic            ref_clk,
   input  wire logic            rst_b,
   input  wire logic            enable,
   input  wire logic            hue_composite,
   input  wire logic [7:0]      black_ofs,
   input  wire logic [7:0]      gain,
   input  wire logic [7:0]      sat,
   input  wire logic [7:0]      hue,
   input  wire gfs_pkg::gfs_pix_t pix_in,
   output gfs_pkg::gfs_pix_t    pix_out
);
   // ********************************************************************
   // arithmetic
   // ********************************************************************
   // hue as signed angle, small-angle sine/cosine approximation in q7
   function automatic logic signed [19:0] mul_q7(
      input logic signed [10:0] a,
      input logic signed [8:0]  b);
      logic signed [19:0] p;
      p = 20'(a * b);
      return p >>> 7;
   endfunction

   wire logic signed [8:0]  hue_s   = {hue[7], hue};
   // square taken at full width so the correction term is not lost
   wire logic signed [8:0]  cos_q7  = 9'sh080
                                    - 9'((18'(hue_s) * 18'(hue_s)) >>> 9);
   wire logic signed [8:0]  sin_q7  = hue_s;
   // composite mode weights the v axis unequally, as an analogue decoder
   wire logic signed [8:0]  sin_cb  = hue_composite ? (sin_q7 >>> 1) : sin_q7;
   wire logic signed [8:0]  sin_cr  = hue_composite ? sin_q7 + (sin_q7 >>> 1)
                                                     : sin_q7;
   wire logic signed [8:0]  sat_s   = {1'b0, sat};
   wire logic signed [8:0]  gain_s  = {1'b0, gain};
   wire logic signed [10:0] y_ofs   = 11'({1'b0, pix_in.y}) + 11'(black_ofs);
   wire logic signed [19:0] y_g     = mul_q7(y_ofs, gain_s);
   wire logic signed [19:0] cb_r    = mul_q7(11'(pix_in.cb), cos_q7)
                                    - mul_q7(11'(pix_in.cr), sin_cb);
   wire logic signed [19:0] cr_r    = mul_q7(11'(pix_in.cr), cos_q7)
                                    + mul_q7(11'(pix_in.cb), sin_cr);
   wire logic signed [19:0] cb_s    = mul_q7(11'(cb_r), sat_s);
   wire logic signed [19:0] cr_s    = mul_q7(11'(cr_r), sat_s);
   wire logic [9:0]         y_sat   = (y_g > 20'sd1023) ? 10'h3FF :
                                      (y_g < 20'sd0) ? 10'h000 : y_g[9:0];

   gfs_pkg::gfs_pix_t adj;
   assign adj.valid = pix_in.valid;
   assign adj.y     = y_sat;
   assign adj.cb    = cb_s[9:0];
   assign adj.cr    = cr_s[9:0];

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pix_out <= '0;
      end else begin
         pix_out <= enable ? adj : pix_in;
      end
   end
endmodule // gfs_proc_amp

// ### hdl/gfs_frame_delay.sv
// frame store: one frame of delay with vertical and horizontal phase
module gfs_frame_delay #(
   parameter int DEPTH = 1024,
   parameter int AW    = 10
) (
   input  wire logic            ref_clk,
   input  wire logic            rst_b,
   input  wire gfs_pkg::gfs_pix_t pix_in,
   input  wire logic [AW-1:0]   frame_len,
   input  wire logic [AW-1:0]   phase_ofs,
   output gfs_pkg::gfs_pix_t    pix_out
);
   // ********************************************************************
   // storage
   // ********************************************************************
   // one frame reduced to frame_len samples, at most DEPTH; real frames need external memory
   gfs_pkg::gfs_pix_t mem [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] wr_next;
   wire  logic [AW:0]   rd_sum = {1'b0, wr_reg} + {1'b0, phase_ofs};
   wire  logic [AW-1:0] rd_addr = (rd_sum >= {1'b0, frame_len})
                                  ? AW'(rd_sum - {1'b0, frame_len})
                                  : rd_sum[AW-1:0];

   assign wr_next = (wr_reg + 1'b1 >= frame_len) ? '0 : wr_reg + 1'b1;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_reg <= '0;
      end else if (pix_in.valid) begin
         wr_reg <= wr_next;
      end
   end

   // zero phase reads the slot written one frame ago
   always_ff @(posedge ref_clk) begin
      if (pix_in.valid) begin
         mem[wr_reg] <= pix_in;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pix_out <= '0;
      end else begin
         pix_out       <= mem[rd_addr];
         pix_out.valid <= pix_in.valid;
      end
   end
endmodule // gfs_frame_delay

// ### hdl/gfs_genlock_timing.sv
// genlock frame sync timing: top level with avalon-mm register slave
// ***********************************************************************
// Contract
// - lock to software-selected source
// - auto-detect external reference type, then lock
// - free-run ignores every reference input
// - missing selected reference forces free-run
// - zero phase gives exactly one frame delay
// - vertical phase shifts all outputs
// - horizontal phase shifts all outputs, pixel clocks
// - subcarrier phase only on composite outputs
// - free-run clock trim plus minus 8 ppm
// - proc amp enable, bypass at unity
// - offset, gain, saturation and hue adjustments
// - component or composite hue mode
// - proc amp ahead of frame capture
// - defaults command restores unity adjustments
// - hours counter refreshed every 3.75 minutes; HOURS reads drop the low 4 bits, so the value read moves once an hour
// - lock status: locked, unlocked, free-run
// - health: normal, transient, failure
// - memory card present or absent
// ***********************************************************************
//
// Chosen here: register access over Avalon-MM and the address map.
`include "gfs_map.svh"

module gfs_genlock_timing #(
   parameter int       LINE_LEN   = 32,
   parameter int       FRAME_LINES= 32,
   parameter int       AW         = 11,
   parameter longint   HOUR_TICK_CYC = `GFS_HOUR_TICK_CYC,
   parameter longint   SIG_TIMEOUT   = `GFS_SIG_TIMEOUT_CYC,
   parameter logic [31:0] DEVICE_ID = 32'h0000_A5A5  // arbitrary value
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rst_b,
   // avalon-mm slave
   input  wire logic [5:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic [31:0]                avs_readdata,
   output logic                       avs_waitrequest,
   // references and video
   input  wire gfs_pkg::gfs_ref_obs_t ref_obs,
   input  wire gfs_pkg::gfs_pix_t     vid_in,
   input  wire logic                  card_present,
   input  wire logic                  fault_detect,
   output gfs_pkg::gfs_pix_t          vid_out,
   output gfs_pkg::gfs_tim_t          tim_out,
   output logic [31:0]                sc_phase_out,
   output logic signed [4:0]          ppm_trim_out
);

   localparam logic [AW-1:0] FRAME_LEN = AW'(LINE_LEN * FRAME_LINES);

   // ********************************************************************
   // registers
   // ********************************************************************
   logic [1:0]          src_reg;
   logic                proc_en_reg;
   logic                hue_mode_reg;
   logic [1:0]          health_reg;
   logic [15:0]         vphase_reg;
   logic [15:0]         hphase_reg;
   logic [15:0]         scphase_reg;
   logic signed [4:0]   ppm_reg;
   logic [7:0]          black_reg, gain_reg, sat_reg, hue_reg;
   logic [31:0]         hours_reg;
   logic [63:0]         tick_reg;
   logic [3:0]          frac_reg;
   logic [63:0]         miss_reg;
   logic [1:0]          lock_reg;
   logic [2:0]          kind_reg;
   logic [AW-1:0]       pos_reg;
   logic                ack_reg;

   // ********************************************************************
   // bus decode
   // ********************************************************************
   wire logic       req        = (avs_read | avs_write) & ~ack_reg;
   // a write lands on the edge where the master sees waitrequest low
   wire logic       wr_hit     = avs_write & ack_reg;
   wire logic       be0        = avs_byteenable[0];
   wire logic       be1        = avs_byteenable[1];
   wire logic       wr_ctrl    = wr_hit & (avs_address == `GFS_OFF_CTRL);
   wire logic       wr_vph     = wr_hit & (avs_address == `GFS_OFF_VPHASE);
   wire logic       wr_hph     = wr_hit & (avs_address == `GFS_OFF_HPHASE);
   wire logic       wr_scph    = wr_hit & (avs_address == `GFS_OFF_SCPHASE);
   wire logic       wr_ppm     = wr_hit & (avs_address == `GFS_OFF_PPM);
   wire logic       wr_proc    = wr_hit & (avs_address == `GFS_OFF_PROC);
   wire logic       wr_proc2   = wr_hit & (avs_address == `GFS_OFF_PROC2);
   wire logic       defaults   = wr_ctrl & be0
                               & avs_writedata[`GFS_CTRL_DEFAULTS];
   wire logic signed [31:0] ppm_wr = avs_writedata;
   // whole word compared, so large values saturate instead of wrapping
   wire logic signed [4:0] ppm_clip = (ppm_wr > `GFS_PPM_MAX) ? `GFS_PPM_MAX
                                    : (ppm_wr < `GFS_PPM_MIN) ? `GFS_PPM_MIN
                                    : ppm_wr[4:0];

   // ********************************************************************
   // reference selection and lock
   // ********************************************************************
   wire logic       sel_free   = (src_reg == gfs_pkg::GFS_SRC_FREE);
   wire logic       sel_sdi    = (src_reg == gfs_pkg::GFS_SRC_SDI);
   wire logic       sdi_ok     = ref_obs.sdi_rate != gfs_pkg::GFS_SDI_BAD;
   wire logic       ref_ok     = ref_obs.ref_kind != gfs_pkg::GFS_REF_NONE;
   // free-run never looks at either reference
   wire logic       sel_frame  = sel_free ? 1'b0
                               : sel_sdi ? (ref_obs.sdi_frame & sdi_ok)
                               : (ref_obs.ref_frame & ref_ok);
   wire logic       sel_valid  = sel_sdi ? sdi_ok : ref_ok;
   wire logic       ref_lost   = ~sel_free & (~sel_valid
                               | (miss_reg >= SIG_TIMEOUT));
   wire logic [1:0] lock_next  = sel_free ? gfs_pkg::GFS_LOCK_FREE
                               : ref_lost ? gfs_pkg::GFS_LOCK_UNLOCK
                               : gfs_pkg::GFS_LOCK_LOCKED;
   // absent reference falls back to free-running counters
   wire logic       do_lock    = ~sel_free & ~ref_lost & sel_frame;
   wire logic [AW-1:0] pos_inc = (pos_reg + 1'b1 >= FRAME_LEN)
                               ? '0 : pos_reg + 1'b1;
   wire logic [AW-1:0] pos_next = do_lock ? '0 : pos_inc;

   // ********************************************************************
   // phase arithmetic
   // ********************************************************************
   function automatic logic [AW-1:0] deg_to_pos(input logic [15:0] deg,
                                                input logic [AW-1:0] len);
      logic [31:0] p;
      p = ({16'h0000, deg} % 32'd360) * 32'(len) / 32'd360;
      return AW'(p);
   endfunction

   wire logic [AW-1:0] vph_pos = deg_to_pos(vphase_reg, FRAME_LEN);
   wire logic [AW:0]   ofs_sum = {1'b0, vph_pos}
                               + {1'b0, AW'(hphase_reg)};
   wire logic [AW-1:0] ofs_all = (ofs_sum >= {1'b0, FRAME_LEN})
                               ? AW'(ofs_sum - {1'b0, FRAME_LEN})
                               : ofs_sum[AW-1:0];
   wire logic [AW:0]   tim_sum = {1'b0, pos_reg} + {1'b0, ofs_all};
   wire logic [AW-1:0] tim_pos = (tim_sum >= {1'b0, FRAME_LEN})
                               ? AW'(tim_sum - {1'b0, FRAME_LEN})
                               : tim_sum[AW-1:0];
   wire logic [31:0]   sc_next = 32'({16'h0000, scphase_reg} % 32'd360);

   // ********************************************************************
   // hours counter: 16 ticks of 225 s make one hour
   // ********************************************************************
   wire logic tick_done = (tick_reg >= 64'(HOUR_TICK_CYC) - 64'd1);

   // ********************************************************************
   // video path
   // ********************************************************************
   gfs_pkg::gfs_pix_t pa_out;
   gfs_pkg::gfs_pix_t fd_out;

   // the amp feeds the frame store so captures already carry adjustment
   gfs_proc_amp u_amp (
      .ref_clk       (ref_clk),
      .rst_b         (rst_b),
      .enable        (proc_en_reg),
      .hue_composite (hue_mode_reg),
      .black_ofs     (black_reg),
      .gain          (gain_reg),
      .sat           (sat_reg),
      .hue           (hue_reg),
      .pix_in        (vid_in),
      .pix_out       (pa_out)
   );

   gfs_frame_delay #(.DEPTH(1 << AW), .AW(AW)) u_fd (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .pix_in    (pa_out),
      .frame_len (FRAME_LEN),
      .phase_ofs (ofs_all),
      .pix_out   (fd_out)
   );

   // ********************************************************************
   // read mux
   // ********************************************************************
   wire logic [31:0] rd_data =
      (avs_address == `GFS_OFF_CTRL)    ? {22'h0, health_reg, 3'h0,
                                           hue_mode_reg, proc_en_reg, 1'b0,
                                           src_reg} :
      (avs_address == `GFS_OFF_VPHASE)  ? {16'h0, vphase_reg} :
      (avs_address == `GFS_OFF_HPHASE)  ? {16'h0, hphase_reg} :
      (avs_address == `GFS_OFF_SCPHASE) ? {16'h0, scphase_reg} :
      (avs_address == `GFS_OFF_PPM)     ? {{27{ppm_reg[4]}}, ppm_reg} :
      (avs_address == `GFS_OFF_PROC)    ? {16'h0, gain_reg, black_reg} :
      (avs_address == `GFS_OFF_PROC2)   ? {16'h0, hue_reg, sat_reg} :
      (avs_address == `GFS_OFF_STATUS)  ? {24'h0, card_present,
                                           kind_reg, health_reg,
                                           lock_reg} :
      (avs_address == `GFS_OFF_HOURS)   ? {hours_reg[31:4], 4'h0} :
      (avs_address == `GFS_OFF_ID)      ? DEVICE_ID :
      32'h0000_0000;

   // ********************************************************************
   // sequential logic
   // ********************************************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_reg         <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else begin
         ack_reg         <= req;
         avs_waitrequest <= ~req;
         avs_readdata    <= rd_data;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         src_reg      <= gfs_pkg::GFS_SRC_FREE;
         proc_en_reg  <= 1'b0;
         hue_mode_reg <= 1'b0;
         health_reg   <= gfs_pkg::GFS_HLTH_BUSY;
      end else begin
         if (wr_ctrl && be0) begin
            src_reg      <= avs_writedata[1:0];
            proc_en_reg  <= avs_writedata[`GFS_CTRL_PROC_EN];
            hue_mode_reg <= avs_writedata[`GFS_CTRL_HUE_MODE];
         end
         // hardware fault wins over the firmware's own report
         if (fault_detect) begin
            health_reg <= gfs_pkg::GFS_HLTH_FAIL;
         end else if (wr_ctrl && be1) begin
            health_reg <= avs_writedata[9:8];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         vphase_reg  <= 16'h0000;
         hphase_reg  <= 16'h0000;
         scphase_reg <= 16'h0000;
         ppm_reg     <= 5'sd0;
      end else begin
         if (wr_vph)  vphase_reg  <= avs_writedata[15:0];
         if (wr_hph)  hphase_reg  <= avs_writedata[15:0];
         if (wr_scph) scphase_reg <= avs_writedata[15:0];
         if (wr_ppm)  ppm_reg     <= ppm_clip;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         black_reg <= `GFS_UNITY_OFFSET;
         gain_reg  <= `GFS_UNITY_GAIN;
         sat_reg   <= `GFS_UNITY_GAIN;
         hue_reg   <= `GFS_UNITY_HUE;
      end else if (defaults) begin
         black_reg <= `GFS_UNITY_OFFSET;
         gain_reg  <= `GFS_UNITY_GAIN;
         sat_reg   <= `GFS_UNITY_GAIN;
         hue_reg   <= `GFS_UNITY_HUE;
      end else begin
         if (wr_proc) begin
            black_reg <= avs_writedata[7:0];
            gain_reg  <= avs_writedata[15:8];
         end
         if (wr_proc2) begin
            sat_reg <= avs_writedata[7:0];
            hue_reg <= avs_writedata[15:8];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         miss_reg <= 64'd0;
         lock_reg <= gfs_pkg::GFS_LOCK_FREE;
         kind_reg <= gfs_pkg::GFS_REF_NONE;
         pos_reg  <= '0;
      end else begin
         miss_reg <= (sel_frame || sel_free) ? 64'd0
                   : (miss_reg >= SIG_TIMEOUT) ? miss_reg : miss_reg + 64'd1;
         lock_reg <= lock_next;
         kind_reg <= ref_obs.ref_kind;
         pos_reg  <= pos_next;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tick_reg  <= 64'd0;
         hours_reg <= 32'h0000_0000;
      end else begin
         tick_reg  <= tick_done ? 64'd0 : tick_reg + 64'd1;
         if (tick_done) hours_reg <= hours_reg + 32'd1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         vid_out      <= '0;
         tim_out      <= '0;
         sc_phase_out <= 32'h0000_0000;
         ppm_trim_out <= 5'sd0;
      end else begin
         vid_out             <= fd_out;
         tim_out.frame_start <= (tim_pos == '0);
         tim_out.line_start  <= (32'(tim_pos) % 32'(LINE_LEN)) == 32'd0;
         tim_out.sc_zero     <= (tim_pos == '0) & ~sel_free;
         sc_phase_out        <= sc_next;
         // trim applied in free-run and while the selected reference is lost
         ppm_trim_out        <= sel_free | ref_lost ? ppm_reg : 5'sd0;
      end
   end
endmodule // gfs_genlock_timing

// ### bench/gfs_genlock_timing_props.sv
// port-level checks for the genlock frame sync timing block
module gfs_genlock_timing_props (
   input wire logic              ref_clk,
   input wire logic              rst_b,
   input wire logic [5:0]        avs_address,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic [31:0]       avs_readdata,
   input wire logic              avs_waitrequest,
   input wire gfs_pkg::gfs_tim_t tim_out,
   input wire logic [31:0]       sc_phase_out,
   input wire logic signed [4:0] ppm_trim_out
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   wire req = avs_read | avs_write;
   a_ack_single: assert property (
      !avs_waitrequest |=> avs_waitrequest) else $error("ack held too long");
   a_ack_cause: assert property (
      !avs_waitrequest |-> $past(req)) else $error("ack without request");
   a_ack_prompt: assert property (
      req && avs_waitrequest |=> !avs_waitrequest) else $error("ack late");
   a_unmapped_zero: assert property (avs_read && !avs_waitrequest
      && avs_address > 6'h24 |-> avs_readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_ppm_range: assert property (ppm_trim_out <= 5'sh8
      && ppm_trim_out >= -5'sh8) else $error("trim out of range");
   a_sc_range: assert property (sc_phase_out < 32'h0000_0168)
      else $error("subcarrier phase out of range");
   a_line_pulse: assert property (
      tim_out.line_start |=> !tim_out.line_start)
      else $error("line strobe not a pulse");
   a_frame_line: assert property (
      tim_out.frame_start |-> tim_out.line_start)
      else $error("frame start off a line start");
endmodule // gfs_genlock_timing_props
bind gfs_genlock_timing gfs_genlock_timing_props u_props (.ref_clk, .rst_b,
   .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
   .tim_out, .sc_phase_out, .ppm_trim_out);

// ### bench/gfs_ref_src.sv
// far-side model: external sync reference and sdi camera feed
module gfs_ref_src #(parameter int PERIOD = 32) (
   input  wire logic                   clk,
   input  wire logic                   ref_on,
   input  wire logic                   sdi_on,
   input  wire gfs_pkg::gfs_ref_kind_t kind,
   input  wire gfs_pkg::gfs_sdi_rate_t rate,
   output gfs_pkg::gfs_ref_obs_t       obs
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   initial obs = '0;
   always @(posedge clk) begin
      cnt <= (cnt + 1) % PERIOD;
      obs.ref_frame <= ref_on && cnt == 0;
      obs.ref_kind <= ref_on ? kind : gfs_pkg::GFS_REF_NONE;
      obs.sdi_frame <= sdi_on && cnt == 0;
      obs.sdi_rate <= sdi_on ? rate : gfs_pkg::GFS_SDI_BAD;
   end
endmodule // gfs_ref_src

// ### bench/gfs_genlock_timing_test.sv
// self-checking bench for the genlock frame sync timing block
module gfs_genlock_timing_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 0, rst_b = 0, rd = 0, wr = 0, ref_on = 0, sdi_on = 0;
   logic [5:0] addr = 6'h00;
   logic [31:0] wdat = 32'h0000_0000, rdat, scp, q, h0;
   logic wreq, flt = 0, card = 0;
   logic signed [4:0] ppm;
   gfs_pkg::gfs_ref_kind_t kind = gfs_pkg::GFS_REF_CSYNC;
   gfs_pkg::gfs_sdi_rate_t rate = gfs_pkg::GFS_SDI_SD;
   gfs_pkg::gfs_ref_obs_t obs;
   gfs_pkg::gfs_pix_t vid = '0, vout;
   gfs_pkg::gfs_tim_t tim;
   gfs_pkg::gfs_pix_t vq[$];
   int n_mismatch = 0, checked = 0;
   int ppm_tab[4] = '{-20, -8, 3, 20};
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) vid <= {1'b1, 30'($urandom)};
   // one frame of 32 samples plus three pipeline registers, amp bypassed
   always @(posedge ref_clk) begin
      if (!rst_b) vq.delete();
      else begin
         vq.push_back(vid);
         if (vq.size() > 35) chk(vout, vq.pop_front());
      end
   end
   gfs_genlock_timing #(.LINE_LEN(8), .FRAME_LINES(4), .HOUR_TICK_CYC(10),
      .SIG_TIMEOUT(50)) u_dut (.ref_clk, .rst_b, .avs_address(addr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
      .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wreq),
      .ref_obs(obs), .vid_in(vid), .card_present(card), .fault_detect(flt),
      .vid_out(vout), .tim_out(tim), .sc_phase_out(scp), .ppm_trim_out(ppm));
   gfs_ref_src u_src (.clk(ref_clk), .ref_on, .sdi_on, .kind, .rate, .obs);
   // trim model: software value clipped to the documented range
   function automatic int clip(int v);
      return v > 8 ? 8 : (v < -8 ? -8 : v);
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge ref_clk);
      addr <= a;
      wdat <= d;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wreq !== 1'b0 && n < 40);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 40) begin
         chk(0, 1);
         results();
      end
   endtask
   task automatic lockwait(input logic [1:0] want);
      bus(0, 6'h1c, 0);
      repeat (40) if (q[1:0] !== want) bus(0, 6'h1c, 0);
      chk(q[1:0], want);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge ref_clk);
      n_mismatch++;
      results();
   end
   initial begin
      void'($urandom(32'h535e));
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'b1;
      bus(0, 6'h00, 0);
      chk(q[1:0], 2);
      lockwait(gfs_pkg::GFS_LOCK_FREE);
      chk(q[7], 0);
      foreach (ppm_tab[i]) begin
         bus(1, 6'h10, 32'(ppm_tab[i]));
         bus(0, 6'h10, 0);
         chk(32'(ppm), 32'(clip(ppm_tab[i])));
      end
      kind <= gfs_pkg::gfs_ref_kind_t'($urandom_range(5, 1));
      ref_on <= 1'b1;
      bus(1, 6'h00, 0);
      lockwait(gfs_pkg::GFS_LOCK_LOCKED);
      chk(q[6:4], kind);
      chk(32'(ppm), 0);
      bus(1, 6'h00, 32'h0000_0002);
      lockwait(gfs_pkg::GFS_LOCK_FREE);
      bus(1, 6'h00, 0);
      lockwait(gfs_pkg::GFS_LOCK_LOCKED);
      ref_on <= 1'b0;
      repeat (200) if (ppm === 5'sh0) @(posedge ref_clk);
      chk(32'(ppm), 32'h0000_0008);
      rate <= gfs_pkg::gfs_sdi_rate_t'($urandom_range(2, 0));
      sdi_on <= 1'b1;
      bus(1, 6'h00, 32'h0000_0001);
      lockwait(gfs_pkg::GFS_LOCK_LOCKED);
      bus(1, 6'h14, 32'h0000_1234);
      bus(1, 6'h00, 32'h0000_0010);
      bus(0, 6'h14, 0);
      chk(q, 32'h0000_8000);
      bus(1, 6'h3c, 32'hffff_ffff);
      bus(0, 6'h3c, 0);
      chk(q, 0);
      h0 = $urandom_range(65535, 0);
      bus(1, 6'h0c, h0);
      repeat (2) @(posedge ref_clk);
      chk(scp, h0 % 360);
      flt <= 1'b1;
      card <= 1'b1;
      bus(0, 6'h1c, 0);
      bus(0, 6'h1c, 0);
      chk(q[3:2], gfs_pkg::GFS_HLTH_FAIL);
      chk(q[7], 1);
      bus(0, 6'h20, 0);
      h0 = q;
      // captures 160 cycles apart: sixteen ticks, one hour
      repeat (157) @(posedge ref_clk);
      bus(0, 6'h20, 0);
      chk(q - h0, 32'h0000_0010);
      results();
   end
endmodule // gfs_genlock_timing_test
